// ===== common/sth_pkg.sv
/*
 * Shared constants and types for the serial terminal handshake block:
 * control and status byte layout, reset values, baud timing, state codes.
 * Assumes a 20 MHz system clock; all users import the whole package.
 */
package sth_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_DEFAULT = 19200;
    localparam logic [15:0] BAUD_DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [15:0] BAUD_DIV_MIN = 16'h0004;
    localparam int PAYLOAD_BYTES = 5;
    localparam int PAYLOAD_BITS = 8 * PAYLOAD_BYTES;
    localparam logic [2:0] MAX_LEN = 3'h5;
    localparam int FIFO_DEPTH = 8;
    localparam logic [15:0] IMG_STATUS_BYTE = 16'h01F4;
    localparam logic [15:0] IMG_CONTROL_BYTE = 16'h01F4;
    localparam int CTL_SEND_TOGGLE = 0;
    localparam int CTL_INBOUND_ACK = 1;
    localparam int CTL_SETUP_REQUEST = 2;
    localparam int CTL_LEN_LSB = 4;
    localparam int STS_SEND_ACK = 0;
    localparam int STS_INBOUND_NOTIFY = 1;
    localparam int STS_SETUP_DONE = 2;
    localparam int STS_QUEUE_FULL = 3;
    localparam int STS_LEN_LSB = 4;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic PAR_EN_RESET = 1'b1;
    localparam logic PAR_ODD_RESET = 1'b0;
    localparam logic [7:0] EMUL_ADDR = 8'h63;
    localparam logic [7:0] TENS_WEIGHT = 8'h0A;
    localparam logic [1:0] ADDR_SETTLE = 2'h3;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SETUP = 2'b01,
        ST_READY = 2'b10
    } sth_main_state_type;
endpackage

// ===== verilog/sth_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and a flush input.
 * Assumes DEPTH is a power of two; one clock, clock enable freezes it.
 */
`timescale 1ns/1ns
`default_nettype none
module sth_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_flush,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data,
    output logic o_full
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sth_fifo_state_type;
    sth_fifo_state_type s, next_s;
    logic do_wr, do_rd;

    assign o_full = (s.cnt == (AW+1)'(DEPTH));
    assign o_wr_ready = !o_full;
    assign o_rd_valid = (s.cnt != '0);
    assign o_rd_data = s.mem[s.rp];
    assign do_wr = i_wr_valid && o_wr_ready;
    assign do_rd = i_rd_ready && o_rd_valid;

    always_comb begin
        next_s = s;
        if (i_flush) begin
            next_s.wp = '0;
            next_s.rp = '0;
            next_s.cnt = '0;
        end else begin
            if (do_wr) begin
                next_s.mem[s.wp] = i_wr_data;
                next_s.wp = s.wp + 1'b1;
            end
            if (do_rd) begin
                next_s.rp = s.rp + 1'b1;
            end
            next_s.cnt = s.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s <= '0;
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    a_flush_empties: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_flush && i_clk_en |=> !o_rd_valid && o_wr_ready)
        else $error("flush left data in the fifo");
endmodule
`default_nettype wire

// ===== verilog/sth_uart.sv
/*
 * Serial character engine: one start bit, eight data bits, optional
 * parity, one stop bit. Assumes a filtered receive line on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module sth_uart (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_enable,
    input wire logic [15:0] i_baud_div,
    input wire logic i_parity_en,
    input wire logic i_parity_odd,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    input wire logic [7:0] i_tx_data,
    output logic o_txd,
    input wire logic i_rxd,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_error
);
    typedef struct packed {
        logic tx_busy;
        logic [15:0] tx_timer;
        logic [3:0] tx_left;
        logic [10:0] tx_sh;
        logic txd;
        logic rx_busy;
        logic [15:0] rx_timer;
        logic [3:0] rx_left;
        logic [10:0] rx_sh;
        logic rx_valid;
        logic [7:0] rx_data;
        logic rx_err;
    } sth_uart_state_type;
    sth_uart_state_type s, next_s;

    assign o_tx_ready = !s.tx_busy;
    assign o_txd = s.txd;
    assign o_rx_valid = s.rx_valid;
    assign o_rx_data = s.rx_data;
    assign o_rx_error = s.rx_err;

    always_comb begin
        logic [10:0] nsh;
        logic [7:0] dat;
        nsh = {i_rxd, s.rx_sh[10:1]};
        dat = i_parity_en ? nsh[8:1] : nsh[9:2];
        next_s = s;
        next_s.rx_valid = 1'b0;
        ////////////////////////////////////////////////////////////////
        // Transmit: characters offered while disabled are swallowed
        if (!s.tx_busy) begin
            next_s.txd = 1'b1;
            if (i_tx_valid && i_enable) begin
                next_s.tx_busy = 1'b1;
                next_s.txd = 1'b0;
                next_s.tx_timer = i_baud_div - 16'h0001;
                next_s.tx_sh = {2'h3, (^i_tx_data) ^ i_parity_odd, i_tx_data};
                if (!i_parity_en) begin
                    next_s.tx_sh[8] = 1'b1;
                end
                next_s.tx_left = i_parity_en ? 4'hA : 4'h9;
            end
        end else if (s.tx_timer != 16'h0000) begin
            next_s.tx_timer = s.tx_timer - 16'h0001;
        end else if (s.tx_left == 4'h0) begin
            next_s.tx_busy = 1'b0;
            next_s.txd = 1'b1;
        end else begin
            next_s.txd = s.tx_sh[0];
            next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
            next_s.tx_left = s.tx_left - 4'h1;
            next_s.tx_timer = i_baud_div - 16'h0001;
        end
        ////////////////////////////////////////////////////////////////
        // Receive: sample mid-bit; no holding register, so no overrun
        if (!s.rx_busy) begin
            if (i_enable && !i_rxd) begin
                next_s.rx_busy = 1'b1;
                next_s.rx_timer = {1'b0, i_baud_div[15:1]};
                next_s.rx_left = i_parity_en ? 4'hB : 4'hA;
                next_s.rx_sh = '0;
            end
        end else if (s.rx_timer != 16'h0000) begin
            next_s.rx_timer = s.rx_timer - 16'h0001;
        end else begin
            next_s.rx_sh = nsh;
            next_s.rx_left = s.rx_left - 4'h1;
            next_s.rx_timer = i_baud_div - 16'h0001;
            if (s.rx_left == 4'h1) begin
                next_s.rx_busy = 1'b0;
                next_s.rx_valid = 1'b1;
                next_s.rx_data = dat;
                next_s.rx_err = (i_parity_en ? nsh[0] : nsh[1]) || !nsh[10] ||
                    (i_parity_en && (nsh[9] != ((^dat) ^ i_parity_odd)));
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s <= '{txd: 1'b1, default: '0};
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    a_idle_line_high: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !i_enable && !s.tx_busy |=> o_txd)
        else $error("disabled port drove the line low");
endmodule
`default_nettype wire

// ===== verilog/sth_top.sv
/*
 * Emulated serial terminal: control byte and five payload bytes in,
 * status byte and five payload bytes out, transmit and receive FIFOs,
 * station address selector and the serial line itself.
 * Assumes the control side is synchronous to i_sys_clk; selector
 * switches and the receive line arrive from pins.
 */
`timescale 1ns/1ns
`default_nettype none
module sth_top #(
    parameter int FIFO_WORDS = sth_pkg::FIFO_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic [7:0] i_control_byte,
    input wire logic [sth_pkg::PAYLOAD_BITS-1:0] i_send_payload,
    input wire logic [3:0] i_addr_units,
    input wire logic [3:0] i_addr_tens,
    input wire logic [15:0] i_cfg_baud_div,
    input wire logic i_cfg_parity_en,
    input wire logic i_cfg_parity_odd,
    input wire logic i_rxd,
    output logic [7:0] o_status_byte,
    output logic [sth_pkg::PAYLOAD_BITS-1:0] o_inbound_payload,
    output logic o_txd,
    output logic o_emul_active,
    output logic [7:0] o_station_addr
);
    import sth_pkg::*;

    typedef struct packed {
        sth_main_state_type mstate;
        logic [1:0] settle;
        logic addr_taken;
        logic [7:0] station;
        logic emul;
        logic [7:0] sw_s1;
        logic [7:0] sw_s2;
        logic [7:0] sw_s3;
        logic rxd_s1;
        logic rxd_s2;
        logic rxd_s3;
        logic rxd_f;
        logic [15:0] baud_div;
        logic par_en;
        logic par_odd;
        logic snd_busy;
        logic [2:0] snd_left;
        logic [2:0] snd_idx;
        logic [PAYLOAD_BITS-1:0] snd_buf;
        logic in_busy;
        logic [2:0] in_cnt;
        logic [PAYLOAD_BITS-1:0] in_buf;
        logic [7:0] status;
    } sth_top_state_type;

    localparam sth_top_state_type TOP_RESET = '{
        mstate: ST_RUN,
        baud_div: BAUD_DIV_DEFAULT,
        par_en: PAR_EN_RESET,
        par_odd: PAR_ODD_RESET,
        status: STATUS_RESET,
        rxd_s1: 1'b1,
        rxd_s2: 1'b1,
        rxd_s3: 1'b1,
        rxd_f: 1'b1,
        default: '0
    };

    sth_top_state_type s, next_s;
    logic setup_req, run;
    logic [2:0] req_len, snd_len_req;
    logic [7:0] addr_calc;
    logic snd_start;
    logic txf_wvalid, txf_wready, txf_rvalid, txf_rready;
    logic [7:0] txf_rdata;
    logic rxf_wvalid, rxf_rvalid, rxf_rready, rxf_full;
    logic [7:0] rxf_rdata;
    logic core_en, rx_valid, rx_err;
    logic [7:0] rx_data;

    assign setup_req = i_control_byte[CTL_SETUP_REQUEST];
    assign run = (s.mstate == ST_RUN) && !setup_req;
    assign req_len = i_control_byte[CTL_LEN_LSB +: 3];
    assign snd_len_req = (req_len > MAX_LEN) ? MAX_LEN : req_len;
    assign addr_calc = 8'(s.sw_s3[7:4] * TENS_WEIGHT + {4'h0, s.sw_s3[3:0]});
    assign snd_start = run && !s.snd_busy &&
        (i_control_byte[CTL_SEND_TOGGLE] != s.status[STS_SEND_ACK]);
    assign core_en = s.emul && run;

    ////////////////////////////////////////////////////////////////////
    // Data path: transmit queue feeds the line, line feeds receive queue

    sth_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) u_tx_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_flush(setup_req),
        .i_wr_valid(txf_wvalid),
        .o_wr_ready(txf_wready),
        .i_wr_data(s.snd_buf[8*s.snd_idx +: 8]),
        .o_rd_valid(txf_rvalid),
        .i_rd_ready(txf_rready),
        .o_rd_data(txf_rdata),
        .o_full()
    );

    sth_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) u_rx_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_flush(setup_req),
        .i_wr_valid(rxf_wvalid),
        .o_wr_ready(),
        .i_wr_data(rx_data),
        .o_rd_valid(rxf_rvalid),
        .i_rd_ready(rxf_rready),
        .o_rd_data(rxf_rdata),
        .o_full(rxf_full)
    );

    sth_uart u_uart (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_enable(core_en),
        .i_baud_div(s.baud_div),
        .i_parity_en(s.par_en),
        .i_parity_odd(s.par_odd),
        .i_tx_valid(txf_rvalid),
        .o_tx_ready(txf_rready),
        .i_tx_data(txf_rdata),
        .o_txd(o_txd),
        .i_rxd(s.rxd_f),
        .o_rx_valid(rx_valid),
        .o_rx_data(rx_data),
        .o_rx_error(rx_err)
    );

    // Characters arriving into a full queue are simply not accepted
    assign rxf_wvalid = rx_valid && !rx_err && core_en;
    assign txf_wvalid = run && s.snd_busy && (s.snd_left != 3'h0);
    assign rxf_rready = run && s.in_busy && rxf_rvalid && (s.in_cnt != MAX_LEN);

    ////////////////////////////////////////////////////////////////////
    // Control state

    always_comb begin
        next_s = s;
        next_s.sw_s1 = {i_addr_tens, i_addr_units};
        next_s.sw_s2 = s.sw_s1;
        next_s.sw_s3 = s.sw_s2;
        next_s.rxd_s1 = i_rxd;
        next_s.rxd_s2 = s.rxd_s1;
        next_s.rxd_s3 = s.rxd_s2;
        if (s.rxd_s2 == s.rxd_s3) begin
            next_s.rxd_f = s.rxd_s3;
        end

        // Selector is caught once after reset and then never again
        if (!s.addr_taken) begin
            if (s.settle != ADDR_SETTLE) begin
                next_s.settle = s.settle + 2'h1;
            end else if (s.sw_s2 == s.sw_s3) begin
                next_s.addr_taken = 1'b1;
                next_s.station = addr_calc;
                next_s.emul = (addr_calc == EMUL_ADDR);
            end
        end

        unique case (s.mstate)
            ST_RUN: begin
                if (setup_req) begin
                    next_s.mstate = ST_SETUP;
                end
            end
            ST_SETUP: begin
                next_s.mstate = setup_req ? ST_READY : ST_RUN;
            end
            ST_READY: begin
                if (!setup_req) begin
                    next_s.mstate = ST_RUN;
                end
            end
        endcase

        if (setup_req) begin
            // Port off, transfers abandoned, format reloaded
            next_s.snd_busy = 1'b0;
            next_s.in_busy = 1'b0;
            next_s.par_en = i_cfg_parity_en;
            next_s.par_odd = i_cfg_parity_odd;
            if (s.emul && i_cfg_baud_div >= BAUD_DIV_MIN) begin
                next_s.baud_div = i_cfg_baud_div;
            end else begin
                next_s.baud_div = BAUD_DIV_DEFAULT;
            end
            // Toggle pairs are levelled so no stale request survives
            next_s.status[STS_SEND_ACK] = i_control_byte[CTL_SEND_TOGGLE];
            next_s.status[STS_INBOUND_NOTIFY] = i_control_byte[CTL_INBOUND_ACK];
            next_s.status[STS_LEN_LSB +: 3] = 3'h0;
        end else if (s.mstate == ST_RUN) begin
            // Send side
            if (snd_start) begin
                next_s.snd_busy = 1'b1;
                next_s.snd_left = snd_len_req;
                next_s.snd_idx = 3'h0;
                next_s.snd_buf = i_send_payload;
            end else if (s.snd_busy) begin
                if (s.snd_left == 3'h0) begin
                    next_s.snd_busy = 1'b0;
                    next_s.status[STS_SEND_ACK] = !s.status[STS_SEND_ACK];
                end else if (txf_wready) begin
                    next_s.snd_idx = s.snd_idx + 3'h1;
                    next_s.snd_left = s.snd_left - 3'h1;
                end
            end
            // Inbound side: a new set starts only after the last was acked
            if (!s.in_busy) begin
                if (i_control_byte[CTL_INBOUND_ACK] == s.status[STS_INBOUND_NOTIFY] && rxf_rvalid) begin
                    next_s.in_busy = 1'b1;
                    next_s.in_cnt = 3'h0;
                end
            end else if (rxf_rready) begin
                next_s.in_buf[8*s.in_cnt +: 8] = rxf_rdata;
                next_s.in_cnt = s.in_cnt + 3'h1;
            end else begin
                next_s.in_busy = 1'b0;
                next_s.status[STS_LEN_LSB +: 3] = s.in_cnt;
                next_s.status[STS_INBOUND_NOTIFY] = !s.status[STS_INBOUND_NOTIFY];
            end
        end

        next_s.status[STS_SETUP_DONE] = (next_s.mstate == ST_READY);
        next_s.status[STS_QUEUE_FULL] = rxf_full;
        next_s.status[7] = 1'b0;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s <= TOP_RESET;
        end else if (i_clk_en) begin
            s <= next_s;
        end
    end

    assign o_status_byte = s.status;
    assign o_inbound_payload = s.in_buf;
    assign o_emul_active = s.emul;
    assign o_station_addr = s.station;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_setup_held;
        i_clk_en && setup_req [*2];
    endsequence

    sequence s_send_done;
        s.snd_busy && s.snd_left == 3'h0 && run && i_clk_en;
    endsequence

    a_level_no_request: assert property (
        run && i_clk_en && !s.snd_busy &&
        i_control_byte[CTL_SEND_TOGGLE] == s.status[STS_SEND_ACK] |=> !s.snd_busy)
        else $error("send started without a toggle");

    a_send_length: assert property (
        snd_start && i_clk_en |=> s.snd_busy && s.snd_left == $past(snd_len_req))
        else $error("send length not taken or not clipped to five");

    a_ack_on_finish: assert property (
        s_send_done |=> o_status_byte[STS_SEND_ACK] != $past(o_status_byte[STS_SEND_ACK]) && !s.snd_busy)
        else $error("send_ack did not toggle after loading");

    a_notify_after_ack: assert property (
        $changed(s.status[STS_INBOUND_NOTIFY]) && !$past(setup_req) |-> $past(s.in_busy))
        else $error("inbound_notify toggled without a collected set");

    a_setup_done_shown: assert property (
        s_setup_held |=> o_status_byte[STS_SETUP_DONE] ##0 !s.snd_busy)
        else $error("setup_done missing two cycles into setup");

    a_setup_done_drop: assert property (
        !setup_req && i_clk_en |=> !o_status_byte[STS_SETUP_DONE])
        else $error("setup_done stayed after setup request dropped");

    a_full_flag: assert property (
        rxf_full && i_clk_en |=> o_status_byte[STS_QUEUE_FULL])
        else $error("queue full not reported");

    a_error_dropped: assert property (
        rx_valid && rx_err |-> !rxf_wvalid)
        else $error("bad character offered to the receive queue");

    a_bad_not_queued: assert property (
        rx_valid && rx_err && !rxf_rvalid && i_clk_en |=> !rxf_rvalid)
        else $error("bad character landed in the empty receive queue");

    a_fixed_baud: assert property (
        !s.emul |-> s.baud_div == BAUD_DIV_DEFAULT)
        else $error("baud rate changed outside emulation address");

    a_addr_frozen: assert property (
        s.addr_taken |=> $stable(s.station) && s.addr_taken)
        else $error("station address changed while running");

    a_emul_at_99: assert property (
        o_emul_active |-> o_station_addr == EMUL_ADDR && s.addr_taken)
        else $error("emulation active at another address");
endmodule
`default_nettype wire

// ===== sim/sth_serial_peer.sv
/*
 * Serial device on the far end of the line: sends characters, optionally
 * with a wrong parity bit, and collects what the block transmits.
 * Assumes 8 data bits, even parity, one stop bit at BIT_NS per bit.
 */
`timescale 1ns/1ns
`default_nettype none
module sth_serial_peer #(
    parameter int BIT_NS = 800
) (
    input wire logic i_txd,
    output logic o_rxd
);
    logic [7:0] got_q[$];
    logic [7:0] shift;

    // Idle line sits at mark level
    initial o_rxd = 1'b1;

    ////////////////////////////////////////////////////////////////
    task automatic send_char(input logic [7:0] d, input logic bad);
        logic [10:0] frame;
        frame = {1'b1, (^d) ^ bad, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            o_rxd = frame[i];
            #(BIT_NS);
        end
    endtask

    // Samples mid-bit; parity is not judged here, only the data kept
    always @(negedge i_txd) begin
        #(BIT_NS / 2);
        if (i_txd === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                #(BIT_NS);
                shift[i] = i_txd;
            end
            #(2 * BIT_NS);
            got_q.push_back(shift);
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_serial_terminal_handshake.sv
/*
 * Self-checking bench: acts as the controller on the control and status
 * bytes, with a serial peer on the line. Assumes the divider of 16 is
 * honoured at station 99 after setup.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_serial_terminal_handshake;
    import sth_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] ctl = 8'h00;
    logic [39:0] pay = 40'h55_44_33_22_11;
    logic [3:0] units = 4'h8;
    logic [3:0] tens = 4'h1;
    logic [15:0] baud = 16'h0010;
    logic rxd;
    logic txd;
    logic emul;
    logic [7:0] sts;
    logic [7:0] sta;
    logic [39:0] inpay;
    int n_mismatch = 0;
    int n_compared = 0;

    always #25 clk = ~clk;

    sth_top dut_u (.i_sys_clk(clk), .i_rst(rst), .i_clk_en(ce), .i_control_byte(ctl),
        .i_send_payload(pay), .i_addr_units(units), .i_addr_tens(tens), .i_cfg_baud_div(baud),
        .i_cfg_parity_en(1'b1), .i_cfg_parity_odd(1'b0), .i_rxd(rxd), .o_status_byte(sts),
        .o_inbound_payload(inpay), .o_txd(txd), .o_emul_active(emul), .o_station_addr(sta));

    sth_serial_peer #(.BIT_NS(800)) peer_u (.i_txd(txd), .o_rxd(rxd));

    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic set_ctl(input logic [7:0] v);
        @(posedge clk);
        #5 ctl = v;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #5 rst = 1'b0;
        repeat (8) @(posedge clk);
        #5;
    endtask

    // Bounded wait for one status bit
    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #5;
            n++;
        end while (sts[b] !== v && n < 3000);
        check("status bit wait", {39'h0, sts[b]}, {39'h0, v});
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        #(30000 * 50);
        n_mismatch++;
        stop_test();
    end

    initial begin
        do_reset();
        check("status after reset", sts, 8'h00);
        check("station", sta, 8'h12);
        check("emul off", emul, 1'b0);
        tens = 4'h9;
        units = 4'h9;
        repeat (10) @(posedge clk);
        #5;
        check("station held", sta, 8'h12);
        do_reset();
        check("station 99", sta, 8'h63);
        check("emul on", emul, 1'b1);
        set_ctl(8'h04);
        wait_bit(2, 1'b1);
        set_ctl(8'h00);
        wait_bit(2, 1'b0);
        set_ctl(8'h21);
        wait_bit(0, 1'b1);
        set_ctl(8'h70);
        wait_bit(0, 1'b0);
        repeat (1500) @(posedge clk);
        #5;
        check("tx count", peer_u.got_q.size(), 7);
        check("tx first", peer_u.got_q[0], 8'h11);
        check("tx second", peer_u.got_q[1], 8'h22);
        check("tx last", peer_u.got_q[6], 8'h55);
        peer_u.send_char(8'hA5, 1'b0);
        wait_bit(1, 1'b1);
        check("in len 1", sts[6:4], 3'h1);
        check("in byte", inpay[7:0], 8'hA5);
        peer_u.send_char(8'h3C, 1'b1);
        for (int i = 0; i < 9; i++) peer_u.send_char(i[7:0], 1'b0);
        repeat (20) @(posedge clk);
        #5;
        check("queue full", sts[3], 1'b1);
        set_ctl(8'h02);
        wait_bit(1, 1'b0);
        check("in len 5", sts[6:4], 3'h5);
        check("in set", inpay, 40'h04_03_02_01_00);
        set_ctl(8'h00);
        wait_bit(1, 1'b1);
        check("in len 3", sts[6:4], 3'h3);
        check("in tail", inpay[23:0], 24'h07_06_05);
        // Clock enable low freezes the handshake; empty set still acked
        ce = 1'b0;
        set_ctl(8'h01);
        repeat (10) @(posedge clk);
        #5;
        check("frozen ack", sts[0], 1'b0);
        ce = 1'b1;
        wait_bit(0, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
